// file: logic/dac_ctrl_pkg.sv
// constants and types shared by the quad converter control logic
package dac_ctrl_pkg;
    localparam int CODE_W = 14;
    localparam int CAL_W = 8;
    localparam int NUM_CH = 4;
    localparam int FRAME_BITS = 24;
    localparam int RW_BIT = 23;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int MON_W = 3;
    localparam int SYNC_W = 9;

    typedef logic [CODE_W-1:0] code_t;
    typedef logic [CAL_W-1:0] cal_t;
    typedef logic [3:0] addr_t;
    typedef logic [FRAME_BITS-1:0] frame_t;
    typedef logic [4:0] bit_cnt_t;

    localparam bit_cnt_t FRAME_CNT = 5'h18;

    // register addresses inside a frame
    localparam addr_t ADDR_CTRL = 4'h0;
    localparam addr_t ADDR_MON = 4'h1;
    localparam addr_t ADDR_DATA0 = 4'h4;
    localparam addr_t ADDR_ZERO0 = 4'h8;
    localparam addr_t ADDR_GAIN0 = 4'hc;

    // control register fields
    localparam int CTRL_GPIO_OUT_LSB = 0;
    localparam int CTRL_GPIO_IN_LSB = 2;
    localparam logic [1:0] CTRL_RST = 2'h3;

    // monitor selections
    localparam logic [MON_W-1:0] MON_HIZ = 3'h0;
    localparam logic [MON_W-1:0] MON_AUX = 3'h5;
    localparam logic [MON_W-1:0] MON_RST = 3'h0;

    // reset values and coding
    localparam code_t UNI_RST_CODE = 14'h0000;
    localparam code_t BIP_RST_CODE = 14'h2000;
    localparam code_t SIGN_FLIP = 14'h2000;
    localparam cal_t ZERO_RST = 8'h00;
    localparam cal_t GAIN_RST = 8'h80;

    // synchroniser reset pattern: cs, ld, rst high, sclk, sdi, pols, gpio
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1c3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_SKIP = 2'b10
    } frame_state_t;
endpackage

// file: logic/sync_2ff.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module sync_2ff #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule

// file: logic/quad_dac_serial_load_control.sv
// serial load control for a quad 14-bit converter
//
// Overview of operation
// R1 - shift serial bits only while chip select low
// R2 - serial output released while chip select high
// R3 - load low makes latches follow input registers
// R4 - outputs change together with latch update
// R5 - reset pin forces registers per polarity pins
// R6 - reset pin restores gain, zero calibration
// R7 - gpio pins read inputs, only pull low
// R8 - group a polarity pin selects uni/bipolar
// R9 - straight binary unipolar, twos complement bipolar
// R10 - channels 2, 3 form separate group b
// R11 - monitor register selects monitor source or hiz
// R12 - fourteen-bit code per channel, four channels
`timescale 1ns/10ps
module quad_dac_serial_load_control (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe_n,
    input wire logic load_latch_n,
    input wire logic rst_pin_n,
    input wire logic polarity_select_group_a,
    input wire logic polarity_select_group_b,
    input wire logic [1:0] gpio_in,
    output logic [1:0] gpio_out,
    output logic [1:0] gpio_oe_n,
    output dac_ctrl_pkg::code_t dac_code_0,
    output dac_ctrl_pkg::code_t dac_code_1,
    output dac_ctrl_pkg::code_t dac_code_2,
    output dac_ctrl_pkg::code_t dac_code_3,
    output logic [dac_ctrl_pkg::MON_W-1:0] monitor_select,
    output logic monitor_hiz
);
    import dac_ctrl_pkg::*;

    logic [SYNC_W-1:0] pins_s;
    logic cs_s, sclk_s, sdi_s, ld_s, rstp_s, pol_a_s, pol_b_s;
    logic [1:0] gpio_s;

    // every pin passes two flops before any logic looks at it
    sync_2ff #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .d({cs_n, load_latch_n, rst_pin_n, sclk, sdi, polarity_select_group_a,
            polarity_select_group_b, gpio_in}),
        .q(pins_s)
    );

    assign cs_s = pins_s[8];
    assign ld_s = pins_s[7];
    assign rstp_s = pins_s[6];
    assign sclk_s = pins_s[5];
    assign sdi_s = pins_s[4];
    assign pol_a_s = pins_s[3];
    assign pol_b_s = pins_s[2];
    assign gpio_s = pins_s[1:0];

    // channel to group: 0,1 in group a, 2,3 in group b
    function automatic logic bipolar_f(input int ch, input logic pa, input logic pb);
        logic grp_b;
        grp_b = (ch >= 2); // see R10
        bipolar_f = grp_b ? !pb : !pa; // see R8
    endfunction

    // reset code depends on the group mode; midscale is 0 V when bipolar
    function automatic code_t rst_code_f(input logic bip);
        rst_code_f = bip ? BIP_RST_CODE : UNI_RST_CODE;
    endfunction

    frame_state_t state_q, state_d;
    bit_cnt_t cnt_q, cnt_d;
    frame_t rx_q, rx_d;
    frame_t tx_q, tx_d;
    logic sclk_prev_q, sclk_prev_d;
    logic cs_prev_q, cs_prev_d;
    code_t in_q [NUM_CH];
    code_t in_d [NUM_CH];
    code_t latch_q [NUM_CH];
    code_t latch_d [NUM_CH];
    cal_t zero_q [NUM_CH];
    cal_t zero_d [NUM_CH];
    cal_t gain_q [NUM_CH];
    cal_t gain_d [NUM_CH];
    logic [MON_W-1:0] mon_q, mon_d;
    logic [1:0] ctrl_q, ctrl_d;

    // readback word for an address; unmapped reads as zero
    function automatic logic [15:0] read_word_f(input addr_t a);
        logic [15:0] w;
        w = 16'h0000;
        if (a == ADDR_CTRL) begin
            w[CTRL_GPIO_OUT_LSB +: 2] = ctrl_q;
            w[CTRL_GPIO_IN_LSB +: 2] = gpio_s; // see R7
        end else if (a == ADDR_MON) begin
            w[MON_W-1:0] = mon_q;
        end else if (a[3:2] == ADDR_DATA0[3:2]) begin
            w[CODE_W-1:0] = in_q[a[1:0]];
        end else if (a[3:2] == ADDR_ZERO0[3:2]) begin
            w[CAL_W-1:0] = zero_q[a[1:0]];
        end else if (a[3:2] == ADDR_GAIN0[3:2]) begin
            w[CAL_W-1:0] = gain_q[a[1:0]];
        end
        read_word_f = w;
    endfunction

    // frame end is seen from the level of chip select, so no rise detector is needed
    logic sclk_rise, sclk_fall, cs_fall;
    assign sclk_rise = sclk_s && !sclk_prev_q;
    assign sclk_fall = !sclk_s && sclk_prev_q;
    assign cs_fall = !cs_s && cs_prev_q;

    // frame engine and register updates
    always_comb begin
        addr_t a;
        code_t wcode;
        logic commit;
        a = rx_q[ADDR_MSB:ADDR_LSB];
        wcode = rx_q[CODE_W-1:0];
        commit = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        sclk_prev_d = sclk_s;
        cs_prev_d = cs_s;
        in_d = in_q;
        latch_d = latch_q;
        zero_d = zero_q;
        gain_d = gain_q;
        mon_d = mon_q;
        ctrl_d = ctrl_q;
        case (state_q)
            ST_IDLE: begin
                if (cs_fall) begin
                    state_d = ST_SHIFT;
                    cnt_d = 5'h00;
                    rx_d = '0;
                end
            end
            ST_SHIFT: begin
                if (cs_s) begin
                    // short frames are dropped whole
                    commit = (cnt_q == FRAME_CNT);
                    state_d = ST_IDLE;
                end else if (sclk_rise) begin
                    if (cnt_q == FRAME_CNT) begin
                        state_d = ST_SKIP; // overlong frame ignored
                    end else begin
                        rx_d = {rx_q[FRAME_BITS-2:0], sdi_s}; // see R1
                        cnt_d = cnt_q + 5'h01;
                    end
                end else if (sclk_fall) begin
                    tx_d = {tx_q[FRAME_BITS-2:0], 1'b0};
                end
            end
            ST_SKIP: begin
                if (cs_s) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (commit) begin
            // read result goes out during the following frame
            tx_d = {rx_q[RW_BIT], 3'h0, a, read_word_f(a)};
            if (!rx_q[RW_BIT]) begin
                if (a == ADDR_CTRL) begin
                    ctrl_d = rx_q[CTRL_GPIO_OUT_LSB +: 2];
                end else if (a == ADDR_MON) begin
                    mon_d = rx_q[MON_W-1:0]; // see R11
                end else if (a[3:2] == ADDR_DATA0[3:2]) begin
                    // bipolar codes flipped to offset binary for the converter
                    in_d[a[1:0]] = bipolar_f(int'(a[1:0]), pol_a_s, pol_b_s) ? (wcode ^ SIGN_FLIP) : wcode; // see R9
                end else if (a[3:2] == ADDR_ZERO0[3:2]) begin
                    zero_d[a[1:0]] = rx_q[CAL_W-1:0];
                end else if (a[3:2] == ADDR_GAIN0[3:2]) begin
                    gain_d[a[1:0]] = rx_q[CAL_W-1:0];
                end
            end
        end
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (!ld_s) begin
                latch_d[ch] = in_d[ch]; // see R3
            end
            if (!rstp_s) begin
                // reset pin beats writes and loads
                in_d[ch] = rst_code_f(bipolar_f(ch, pol_a_s, pol_b_s)); // see R5
                latch_d[ch] = rst_code_f(bipolar_f(ch, pol_a_s, pol_b_s)); // see R5
                zero_d[ch] = ZERO_RST; // see R6
                gain_d[ch] = GAIN_RST; // see R6
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            rx_q <= '0;
            tx_q <= '0;
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            mon_q <= MON_RST;
            ctrl_q <= CTRL_RST;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                in_q[ch] <= UNI_RST_CODE;
                latch_q[ch] <= UNI_RST_CODE;
                zero_q[ch] <= ZERO_RST;
                gain_q[ch] <= GAIN_RST;
            end
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            sclk_prev_q <= sclk_prev_d;
            cs_prev_q <= cs_prev_d;
            mon_q <= mon_d;
            ctrl_q <= ctrl_d;
            in_q <= in_d;
            latch_q <= latch_d;
            zero_q <= zero_d;
            gain_q <= gain_d;
        end
    end

    // outputs straight from latch flops so channels move together
    assign dac_code_0 = latch_q[0]; // see R4
    assign dac_code_1 = latch_q[1]; // see R4
    assign dac_code_2 = latch_q[2]; // see R12
    assign dac_code_3 = latch_q[3]; // see R12

    // sdo released whenever synced chip select is high (two cycle lag)
    assign sdo_out = tx_q[FRAME_BITS-1];
    assign sdo_oe_n = cs_s; // see R2

    // open drain: drive low only, never high
    assign gpio_out = 2'h0; // see R7
    assign gpio_oe_n = ctrl_q; // see R7

    assign monitor_select = mon_q;
    assign monitor_hiz = (mon_q == MON_HIZ) || (mon_q > MON_AUX); // see R11
endmodule

// file: tb/spi_host_model.sv
// serial host model: frames msb first, link clock idle low between frames
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk_sys,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b1;
    end
    // each link clock half is 4 system clocks (80 ns), above the 3 clock minimum
    task automatic xfer(input logic [23:0] f, input int n, output logic [23:0] rd);
        rd = '0;
        @(negedge clk_sys) cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 24) ? f[23-i] : 1'b0;
            repeat (4) @(negedge clk_sys);
            rd = {rd[22:0], sdo_oe_n ? 1'bz : sdo_out};
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        cs_n = 1'b1;
        sdi = ~sdi;  // no stale bit once released
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

// file: tb/quad_dac_serial_load_control_properties.sv
// port assertions for the quad converter serial load control
`timescale 1ns/10ps
module quad_dac_serial_load_control_properties (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sdo_oe_n,
    input wire logic load_latch_n,
    input wire logic rst_pin_n,
    input wire logic polarity_select_group_a,
    input wire logic polarity_select_group_b,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe_n,
    input wire dac_ctrl_pkg::code_t dac_code_0,
    input wire dac_ctrl_pkg::code_t dac_code_1,
    input wire dac_ctrl_pkg::code_t dac_code_2,
    input wire dac_ctrl_pkg::code_t dac_code_3,
    input wire logic [dac_ctrl_pkg::MON_W-1:0] monitor_select,
    input wire logic monitor_hiz
);
    import dac_ctrl_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // pin windows allow for the two synchroniser stages
    property p_sdo_idle;
        cs_n [*3] |-> sdo_oe_n;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while deselected");
    property p_sdo_sel;
        !sdo_oe_n |-> !$past(cs_n, 2);
    endproperty
    a_sdo_sel: assert property (p_sdo_sel) else $error("sdo driven without select");
    property p_drain;
        gpio_out == 2'h0;
    endproperty
    a_drain: assert property (p_drain) else $error("gpio drives high");
    property p_hold;
        (load_latch_n && rst_pin_n) [*4] |=> $stable(dac_code_0) && $stable(dac_code_1)
            && $stable(dac_code_2) && $stable(dac_code_3);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved while load high");
    property p_rst_a;
        (!rst_pin_n && polarity_select_group_a) [*4] |=> dac_code_0 == UNI_RST_CODE && dac_code_1 == UNI_RST_CODE;
    endproperty
    a_rst_a: assert property (p_rst_a) else $error("group a reset code");
    property p_rst_b;
        (!rst_pin_n && !polarity_select_group_b) [*4] |=> dac_code_2 == BIP_RST_CODE && dac_code_3 == BIP_RST_CODE;
    endproperty
    a_rst_b: assert property (p_rst_b) else $error("group b reset code");
    property p_hiz;
        $stable(monitor_select) [*2] |-> monitor_hiz == (monitor_select == 3'h0 || monitor_select > 3'h5);
    endproperty
    a_hiz: assert property (p_hiz) else $error("monitor hiz mismatch");
    property p_quiet;
        cs_n [*5] |=> $stable(gpio_oe_n) && $stable(monitor_select);
    endproperty
    a_quiet: assert property (p_quiet) else $error("register moved without frame");
    c_read: cover property (!sdo_oe_n ##1 sdo_oe_n);
    c_load: cover property (!load_latch_n ##3 $changed(dac_code_0));
    c_rst: cover property (!rst_pin_n [*4]);
endmodule
bind quad_dac_serial_load_control quad_dac_serial_load_control_properties u_props (.clk_sys, .srst, .cs_n,
    .sdo_oe_n, .load_latch_n, .rst_pin_n, .polarity_select_group_a, .polarity_select_group_b, .gpio_out,
    .gpio_oe_n, .dac_code_0, .dac_code_1, .dac_code_2, .dac_code_3, .monitor_select, .monitor_hiz);

// file: tb/quad_dac_serial_load_control_test.sv
// self-checking bench for the quad converter serial load control
`timescale 1ns/10ps
module quad_dac_serial_load_control_test;
    import dac_ctrl_pkg::*;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic pa; logic pb; logic [15:0] e;} row_t;
    logic clk_sys, srst, cs_n, sclk, sdi, sdo_out, sdo_oe_n, load_latch_n, rst_pin_n, monitor_hiz;
    logic polarity_select_group_a, polarity_select_group_b;
    logic [1:0] gpio_in, gpio_out, gpio_oe_n, gpio_ext;
    logic [MON_W-1:0] monitor_select;
    logic [23:0] rd;
    code_t dac_code_0, dac_code_1, dac_code_2, dac_code_3;
    code_t [3:0] codes;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    // channel writes in each mode, then monitor choices and gpio drive
    row_t rows [10] = '{
        '{4'h4, 16'h3fff, 1'b1, 1'b1, 16'h3fff}, '{4'h5, 16'h1fff, 1'b0, 1'b1, 16'h3fff},
        '{4'h6, 16'h0001, 1'b1, 1'b1, 16'h0001}, '{4'h7, 16'h2000, 1'b1, 1'b0, 16'h0000},
        '{4'h4, 16'h0000, 1'b0, 1'b1, 16'h2000}, '{4'h1, 16'h0005, 1'b1, 1'b1, 16'h0005},
        '{4'h1, 16'h0007, 1'b1, 1'b1, 16'h000f}, '{4'h1, 16'h0000, 1'b1, 1'b1, 16'h0008},
        '{4'h1, 16'h0003, 1'b1, 1'b1, 16'h0003}, '{4'h0, 16'h0002, 1'b1, 1'b1, 16'h0002}
    };
    // open-drain pins: low while driven, otherwise the external level
    assign gpio_in = (gpio_oe_n & gpio_ext) | (~gpio_oe_n & gpio_out);
    assign codes = {dac_code_3, dac_code_2, dac_code_1, dac_code_0};
    spi_host_model host (.clk_sys, .sdo_out, .sdo_oe_n, .cs_n, .sclk, .sdi);
    quad_dac_serial_load_control DUT (.clk_sys, .srst, .cs_n, .sclk, .sdi, .sdo_out, .sdo_oe_n, .load_latch_n,
        .rst_pin_n, .polarity_select_group_a, .polarity_select_group_b, .gpio_in, .gpio_out, .gpio_oe_n,
        .dac_code_0, .dac_code_1, .dac_code_2, .dac_code_3, .monitor_select, .monitor_hiz);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // the output a register address shows up on
    function automatic logic [15:0] probe(input logic [3:0] a);
        if (a == ADDR_CTRL) return {14'h0, gpio_oe_n};
        if (a == ADDR_MON) return {12'h0, monitor_hiz, monitor_select};
        return {2'h0, codes[a[1:0]]};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        load_latch_n = 1'b0;
        rst_pin_n = 1'b1;
        polarity_select_group_a = 1'b1;
        polarity_select_group_b = 1'b1;
        gpio_ext = 2'b11;
        repeat (6) @(negedge clk_sys);
        check({9'h0, gpio_oe_n, sdo_oe_n, monitor_hiz, monitor_select}, 16'h0078);
        check({2'h0, dac_code_0 | dac_code_1 | dac_code_2 | dac_code_3}, 16'h0000);
        srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        // polarity settles through the synchroniser before each write
        foreach (rows[i]) begin
            polarity_select_group_a = rows[i].pa;
            polarity_select_group_b = rows[i].pb;
            repeat (3) @(negedge clk_sys);
            host.xfer({4'h0, rows[i].a, rows[i].d}, 24, rd);
            check(probe(rows[i].a), rows[i].e);
        end
        // double buffering: writes wait for the load pin, then land together
        load_latch_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        host.xfer(24'h040aaa, 24, rd);
        host.xfer(24'h071555, 24, rd);
        check(probe(4'h4), 16'h2000);
        check(probe(4'h7), 16'h0000);
        load_latch_n = 1'b0;
        repeat (5) begin
            @(negedge clk_sys);
            check({15'h0, dac_code_0 == 14'h0aaa}, {15'h0, dac_code_3 == 14'h1555});
        end
        check(probe(4'h4), 16'h0aaa);
        check(probe(4'h7), 16'h1555);
        // one bit short: the frame is dropped (it would write channel 1 if taken)
        host.xfer(24'h0a0246, 23, rd);
        check(probe(4'h5), 16'h3fff);
        // one bit too many: the frame is dropped as well
        host.xfer(24'h050123, 25, rd);
        check(probe(4'h5), 16'h3fff);
        // read back control: pin 0 pulled low, pin 1 left to the pull-up
        host.xfer(24'h800000, 24, rd);
        host.xfer(24'h810000, 24, rd);
        check(rd[15:0], 16'h000a);
        check({8'h0, rd[23:16]}, 16'h0080);
        check({15'h0, sdo_oe_n}, 16'h0001);
        // calibration writes land and read back before the reset pin test
        host.xfer(24'h0c0055, 24, rd);
        host.xfer(24'h090011, 24, rd);
        host.xfer(24'h8c0000, 24, rd);
        host.xfer(24'h890000, 24, rd);
        check(rd[15:0], 16'h0055);
        host.xfer(24'h890000, 24, rd);
        check(rd[15:0], 16'h0011);
        // reset pin forces per-group codes and blocks writes
        polarity_select_group_b = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_pin_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        host.xfer(24'h040123, 24, rd);
        check(probe(4'h4), 16'h0000);
        check(probe(4'h6), 16'h2000);
        rst_pin_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        // calibration back at its defaults after the reset pin
        host.xfer(24'h8c0000, 24, rd);
        host.xfer(24'h890000, 24, rd);
        check(rd[15:0], {8'h0, GAIN_RST});
        host.xfer(24'h890000, 24, rd);
        check(rd[15:0], {8'h0, ZERO_RST});
        tally_and_finish();
    end
endmodule
